// ==== src/spi_pkg.sv ====
// Operation
// - Port runs as master or slave
// - Serial clock at most 10MHz or clk/8
// - Sixteen-bit shift register with data buffer
// - Programmable clock polarity and phase
// - Three, four and five pin arrangements
// - Enable pin handshakes slave readiness
// - Chip select use is optional
// - Every pin usable as general purpose I/O
// - Master toggles or holds select between words
// - Flag register read clears set flags
// - Buffer read empties it, clears flags
// - Mirror read leaves buffer and flags alone
// - Vector read clears vector and its flag
package spi_pkg;

  // ==========================================================
  // Clocking and serial rate limits
  // ==========================================================
  localparam int CLK_HZ        = 20_000_000;  // Peripheral system clock
  localparam int SCLK_LIMIT_HZ = 10_000_000;  // Absolute serial ceiling
  localparam int SCLK_MAX_HZ   = (CLK_HZ / 8 < SCLK_LIMIT_HZ) ?
                                 CLK_HZ / 8 : SCLK_LIMIT_HZ;
  // Least half period in clk cycles, rounded up
  localparam int HALF_MIN_INT  = (CLK_HZ + 2 * SCLK_MAX_HZ - 1) /
                                 (2 * SCLK_MAX_HZ);
  localparam logic [7:0] HALF_MIN = 8'(HALF_MIN_INT);

  // ==========================================================
  // Widths
  // ==========================================================
  localparam int ADDR_W = 8;   // Byte address width
  localparam int DATA_W = 32;  // Register bus width
  localparam int WORD_W = 16;  // Shift register width
  localparam int N_EV   = 3;   // Interrupt events
  localparam int N_PIN  = 5;   // Serial pins

  // ==========================================================
  // Register offsets (byte addresses)
  // ==========================================================
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_DIV    = 8'h04;
  localparam logic [7:0] OFS_TXDATA = 8'h08;
  localparam logic [7:0] OFS_FLAGS  = 8'h10;  // port_flags
  localparam logic [7:0] OFS_MASK   = 8'h14;
  localparam logic [7:0] OFS_LEVEL  = 8'h18;
  localparam logic [7:0] OFS_PFUNC  = 8'h20;
  localparam logic [7:0] OFS_PDIR   = 8'h24;
  localparam logic [7:0] OFS_PDOUT  = 8'h28;
  localparam logic [7:0] OFS_PDIN   = 8'h2c;
  localparam logic [7:0] OFS_RXBUF  = 8'h40;  // receive_buffer
  localparam logic [7:0] OFS_RXMIR  = 8'h44;  // receive_buffer_mirror
  localparam logic [7:0] OFS_VEC0   = 8'h60;  // interrupt_vector_line0
  localparam logic [7:0] OFS_VEC1   = 8'h64;  // interrupt_vector_line1

  // ==========================================================
  // Field positions and reset values
  // ==========================================================
  localparam int EV_RX  = 0;  // Word received
  localparam int EV_OVR = 1;  // Receiver overrun
  localparam int EV_TX  = 2;  // Transmit buffer taken
  localparam int PIN_CLK  = 0;
  localparam int PIN_SIMO = 1;
  localparam int PIN_SOMI = 2;
  localparam int PIN_CS   = 3;
  localparam int PIN_ENA  = 4;
  localparam int RXFULL_BIT = 16;  // Buffer full bit in receive_buffer
  localparam logic [10:0] CTRL_RST = 11'h780;  // Disabled, 16-bit words
  localparam logic [4:0]  PFUNC_RST = 5'h00;   // All pins GPIO
  localparam logic [1:0]  VEC_NONE = 2'h0;

  // Control register layout, bit 10 downward
  typedef struct packed {
    logic [3:0] len_m1;   // Word length minus one
    logic       cs_hold;  // Hold select across words
    logic       ena_use;  // Enable pin in use
    logic       cs_use;   // Chip select in use
    logic       pha;      // Clock phase
    logic       pol;      // Idle clock level
    logic       master;   // Master when set
    logic       enable;   // Port enable
  } ctrl_s;

  // Register bus request
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } bus_req_s;

  typedef enum logic [1:0] {
    M_IDLE  = 2'b00,
    M_WAIT  = 2'b01,
    M_SHIFT = 2'b10,
    M_GAP   = 2'b11
  } master_e;

endpackage

// ==== src/spi_port.sv ====
// Implementation choice: the address-and-strobe port.
module spi_port
  import spi_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             rst_b,
  input  wire bus_req_s         bus,
  output logic [DATA_W-1:0]     rdata,
  output logic                  irq,
  input  wire logic [N_PIN-1:0] pin_in,
  output logic [N_PIN-1:0]      pin_out,
  output logic [N_PIN-1:0]      pin_oe
);

  // ==========================================================
  // Helper functions
  // ==========================================================
  // Left-justify a word so its first bit sits at bit 15
  function automatic logic [WORD_W-1:0] align(
    input logic [WORD_W-1:0] d,
    input logic [3:0]        lm1);
    return d << (4'hf - lm1);
  endfunction

  // Keep only the low bits of a received word
  function automatic logic [WORD_W-1:0] rx_mask(
    input logic [WORD_W-1:0] d,
    input logic [3:0]        lm1);
    return d & (16'hffff >> (4'hf - lm1));
  endfunction

  // Lowest pending event as a vector code, zero when none
  function automatic logic [1:0] vec_of(input logic [N_EV-1:0] p);
    logic [1:0] v;
    v = VEC_NONE;
    for (int i = N_EV - 1; i >= 0; i--) begin
      if (p[i]) begin
        v = 2'(i + 1);
      end
    end
    return v;
  endfunction

  // Flag bit that a vector code stands for
  function automatic logic [N_EV-1:0] vec_bit(input logic [1:0] v);
    return (v == VEC_NONE) ? 3'h0 : 3'(3'h1 << (v - 2'h1));
  endfunction

  // ==========================================================
  // Declarations
  // ==========================================================
  ctrl_s             ctrl_r;        // Mode and word length
  logic [7:0]        div_r;         // Half period in clk cycles
  logic [WORD_W-1:0] txbuf_r;       // Transmit data buffer
  logic              tx_valid_r;    // Transmit buffer loaded
  logic [N_EV-1:0]   flags_r;       // Sticky event flags
  logic [N_EV-1:0]   flags_nxt;
  logic [N_EV-1:0]   mask_r;        // Interrupt enables
  logic [N_EV-1:0]   level_r;       // Vector line select per event
  logic [N_PIN-1:0]  func_r;        // Pin serial function select
  logic [N_PIN-1:0]  dir_r;         // GPIO direction, 1 drives
  logic [N_PIN-1:0]  dout_r;        // GPIO output value
  logic [WORD_W-1:0] rxbuf_r;       // Receive data buffer
  logic              rx_full_r;     // Receive buffer unread
  logic [DATA_W-1:0] rdata_r;
  logic [DATA_W-1:0] rd_val;
  logic              irq_r;
  logic [N_PIN-1:0]  pin_out_r;
  logic [N_PIN-1:0]  pin_oe_r;
  logic [N_PIN-1:0]  meta_r;        // First synchroniser stage
  logic [N_PIN-1:0]  sync_r;        // Second synchroniser stage
  logic [N_PIN-1:0]  prev_r;        // Edge history
  logic [WORD_W-1:0] shift_r;       // Shift register
  logic [WORD_W-1:0] shift_nxt;
  logic              out_bit_r;     // Bit presented on data out
  logic              sclk_r;        // Master serial clock
  logic              cs_n_r;        // Master chip select, active low
  master_e           state_r;
  logic [7:0]        div_cnt_r;
  logic [5:0]        edge_cnt_r;
  logic [4:0]        bit_cnt_r;     // Slave samples taken
  logic              armed_r;       // Slave holds fresh transmit word
  logic [7:0]        half;
  logic [4:0]        wlen;
  logic [5:0]        last_edge;
  logic              m_en, s_en, sel;
  logic              m_tick, m_lead, m_samp, m_shift, m_done, m_load;
  logic              gap_end;
  logic              s_edge, s_lead, s_samp, s_shift, s_done, s_load;
  logic              samp, shift_ev, in_bit, word_done, load;
  logic [WORD_W-1:0] rx_word;
  logic [1:0]        vec0, vec1;
  logic              rd_flags, rd_rxbuf, rd_vec0, rd_vec1;
  logic [N_EV-1:0]   set_ev, clr_ev;
  logic [N_PIN-1:0]  ser_out, ser_oe;

  // ==========================================================
  // Pin synchronisers
  // ==========================================================
  // Two stages before any logic looks at a pin
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      meta_r <= '0;
      sync_r <= '0;
      prev_r <= '0;
    end else begin
      meta_r <= pin_in;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  // ==========================================================
  // Serial timing decode
  // ==========================================================
  always_comb begin
    // Clamp divider so the clock never runs too fast
    half      = (div_r < HALF_MIN) ? HALF_MIN : div_r;
    wlen      = 5'(ctrl_r.len_m1) + 5'h01;
    last_edge = 6'({wlen, 1'b0}) - 6'h01;
    m_en      = ctrl_r.enable && ctrl_r.master;
    s_en      = ctrl_r.enable && !ctrl_r.master;
    // Without a select line the slave is always addressed
    sel       = !ctrl_r.cs_use || !sync_r[PIN_CS];
    // Master edge generation
    m_tick    = (state_r == M_SHIFT) && (div_cnt_r == half - 8'h01);
    m_lead    = (sclk_r == ctrl_r.pol);
    m_samp    = m_tick && (m_lead != ctrl_r.pha);
    m_shift   = m_tick && (m_lead == ctrl_r.pha);
    m_done    = m_tick && (edge_cnt_r == last_edge);
    gap_end   = (state_r == M_GAP) && (div_cnt_r == half - 8'h01);
    m_load    = m_en && tx_valid_r &&
                ((state_r == M_IDLE) || gap_end);
    // Slave edges seen on the synchronised clock pin
    s_edge    = s_en && sel && (sync_r[PIN_CLK] != prev_r[PIN_CLK]);
    s_lead    = (sync_r[PIN_CLK] != ctrl_r.pol);
    s_samp    = s_edge && (s_lead != ctrl_r.pha);
    // With phase 0 the edge after the last sample must not
    // disturb the next word's first bit
    s_shift   = s_edge && (s_lead == ctrl_r.pha) &&
                (ctrl_r.pha || (bit_cnt_r != 5'h00));
    s_done    = s_samp && (bit_cnt_r == wlen - 5'h01);
    s_load    = s_en && tx_valid_r && !armed_r &&
                (bit_cnt_r == 5'h00) && !s_edge;
    // Shared shifter control
    samp      = ctrl_r.master ? m_samp : s_samp;
    shift_ev  = ctrl_r.master ? m_shift : s_shift;
    in_bit    = ctrl_r.master ? sync_r[PIN_SOMI] : sync_r[PIN_SIMO];
    word_done = ctrl_r.master ? m_done : s_done;
    load      = m_load || s_load;
    shift_nxt = samp ? {shift_r[WORD_W-2:0], in_bit} : shift_r;
    rx_word   = rx_mask(shift_nxt, ctrl_r.len_m1);
  end

  // ==========================================================
  // Shift register and data out bit
  // ==========================================================
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      shift_r   <= '0;
      out_bit_r <= 1'b0;
    end else if (load) begin
      // First bit goes out before the first sampling edge
      shift_r   <= align(txbuf_r, ctrl_r.len_m1);
      out_bit_r <= txbuf_r[ctrl_r.len_m1];
    end else begin
      if (samp) begin
        shift_r <= shift_nxt;
      end
      if (shift_ev) begin
        out_bit_r <= shift_r[WORD_W-1];
      end
    end
  end

  // ==========================================================
  // Master sequencer
  // ==========================================================
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state_r    <= M_IDLE;
      sclk_r     <= 1'b0;
      cs_n_r     <= 1'b1;
      div_cnt_r  <= '0;
      edge_cnt_r <= '0;
    end else if (!m_en) begin
      // Leaving master mode abandons the word in flight
      state_r <= M_IDLE;
      sclk_r  <= ctrl_r.pol;
      cs_n_r  <= 1'b1;
    end else begin
      unique case (state_r)
        M_IDLE: begin
          sclk_r <= ctrl_r.pol;
          if (tx_valid_r) begin
            cs_n_r  <= 1'b0;
            state_r <= M_WAIT;
          end
        end
        M_WAIT: begin
          // Hold off until the slave pulls enable low
          if (!ctrl_r.ena_use || !sync_r[PIN_ENA]) begin
            state_r    <= M_SHIFT;
            div_cnt_r  <= '0;
            edge_cnt_r <= '0;
          end
        end
        M_SHIFT: begin
          if (m_tick) begin
            div_cnt_r  <= '0;
            sclk_r     <= ~sclk_r;
            edge_cnt_r <= edge_cnt_r + 6'h01;
            if (m_done) begin
              state_r <= M_GAP;
              // Release between words unless told to hold
              if (!ctrl_r.cs_hold) begin
                cs_n_r <= 1'b1;
              end
            end
          end else begin
            div_cnt_r <= div_cnt_r + 8'h01;
          end
        end
        M_GAP: begin
          if (gap_end) begin
            div_cnt_r <= '0;
            if (tx_valid_r) begin
              cs_n_r  <= 1'b0;
              state_r <= M_WAIT;
            end else begin
              cs_n_r  <= 1'b1;
              state_r <= M_IDLE;
            end
          end else begin
            div_cnt_r <= div_cnt_r + 8'h01;
          end
        end
      endcase
    end
  end

  // ==========================================================
  // Slave bit counting
  // ==========================================================
  // Select may stay low for many words; the counter alone
  // marks the word boundary
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      bit_cnt_r <= '0;
      armed_r   <= 1'b0;
    end else begin
      if (!s_en || !sel || s_done) begin
        bit_cnt_r <= '0;
      end else if (s_samp) begin
        bit_cnt_r <= bit_cnt_r + 5'h01;
      end
      if (s_load) begin
        armed_r <= 1'b1;
      end else if (s_done || !s_en) begin
        armed_r <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Register decode
  // ==========================================================
  always_comb begin
    rd_flags = bus.rd && (bus.addr == OFS_FLAGS);
    rd_rxbuf = bus.rd && (bus.addr == OFS_RXBUF);
    rd_vec0  = bus.rd && (bus.addr == OFS_VEC0);
    rd_vec1  = bus.rd && (bus.addr == OFS_VEC1);
    vec0     = vec_of(flags_r & mask_r & ~level_r);
    vec1     = vec_of(flags_r & mask_r & level_r);
    set_ev          = '0;
    set_ev[EV_RX]   = word_done;
    // Unread word being replaced is an overrun
    set_ev[EV_OVR]  = word_done && rx_full_r && !rd_rxbuf;
    set_ev[EV_TX]   = load;
    clr_ev = '0;
    if (rd_flags || rd_rxbuf) begin
      clr_ev = '1;
    end
    if (rd_vec0) begin
      clr_ev = clr_ev | vec_bit(vec0);
    end
    if (rd_vec1) begin
      clr_ev = clr_ev | vec_bit(vec1);
    end
    if (bus.wr && (bus.addr == OFS_FLAGS)) begin
      clr_ev = clr_ev | bus.wdata[N_EV-1:0];
    end
    // Events raised in the clearing cycle survive
    flags_nxt = (flags_r & ~clr_ev) | set_ev;
  end

  // ==========================================================
  // Software registers
  // ==========================================================
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ctrl_r  <= CTRL_RST;
      div_r   <= HALF_MIN;
      mask_r  <= '0;
      level_r <= '0;
      func_r  <= PFUNC_RST;
      dir_r   <= '0;
      dout_r  <= '0;
    end else if (bus.wr) begin
      unique case (bus.addr)
        OFS_CTRL:  ctrl_r  <= ctrl_s'(bus.wdata[10:0]);
        OFS_DIV:   div_r   <= bus.wdata[7:0];
        OFS_MASK:  mask_r  <= bus.wdata[N_EV-1:0];
        OFS_LEVEL: level_r <= bus.wdata[N_EV-1:0];
        OFS_PFUNC: func_r  <= bus.wdata[N_PIN-1:0];
        OFS_PDIR:  dir_r   <= bus.wdata[N_PIN-1:0];
        OFS_PDOUT: dout_r  <= bus.wdata[N_PIN-1:0];
        default:   ;  // Other writes have their own processes
      endcase
    end
  end

  // Transmit buffer; a write in the load cycle keeps it full
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      txbuf_r    <= '0;
      tx_valid_r <= 1'b0;
    end else if (bus.wr && (bus.addr == OFS_TXDATA)) begin
      txbuf_r    <= bus.wdata[WORD_W-1:0];
      tx_valid_r <= 1'b1;
    end else if (load) begin
      tx_valid_r <= 1'b0;
    end
  end

  // Receive buffer and its full state
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rxbuf_r   <= '0;
      rx_full_r <= 1'b0;
    end else if (word_done) begin
      rxbuf_r   <= rx_word;
      rx_full_r <= 1'b1;
    end else if (rd_rxbuf) begin
      rx_full_r <= 1'b0;
    end
  end

  // Sticky flags and the interrupt line
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      flags_r <= '0;
      irq_r   <= 1'b0;
    end else begin
      flags_r <= flags_nxt;
      irq_r   <= |(flags_nxt & mask_r);
    end
  end

  // ==========================================================
  // Read data, valid only in the cycle after the strobe
  // ==========================================================
  always_comb begin
    rd_val = '0;
    unique case (bus.addr)
      OFS_CTRL:   rd_val[10:0]        = ctrl_r;
      OFS_DIV:    rd_val[7:0]         = div_r;
      OFS_TXDATA: rd_val[WORD_W-1:0]  = txbuf_r;
      OFS_FLAGS:  rd_val[N_EV-1:0]    = flags_r;
      OFS_MASK:   rd_val[N_EV-1:0]    = mask_r;
      OFS_LEVEL:  rd_val[N_EV-1:0]    = level_r;
      OFS_PFUNC:  rd_val[N_PIN-1:0]   = func_r;
      OFS_PDIR:   rd_val[N_PIN-1:0]   = dir_r;
      OFS_PDOUT:  rd_val[N_PIN-1:0]   = dout_r;
      OFS_PDIN:   rd_val[N_PIN-1:0]   = sync_r;
      OFS_RXBUF: begin
        rd_val[WORD_W-1:0] = rxbuf_r;
        rd_val[RXFULL_BIT] = rx_full_r;
      end
      // Mirror shows data only and has no side effect
      OFS_RXMIR:  rd_val[WORD_W-1:0]  = rxbuf_r;
      OFS_VEC0:   rd_val[1:0]         = vec0;
      OFS_VEC1:   rd_val[1:0]         = vec1;
      default:    rd_val              = '0;  // Unmapped reads zero
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rdata_r <= '0;
    end else begin
      rdata_r <= bus.rd ? rd_val : '0;
    end
  end

  // ==========================================================
  // Pin drive: serial role or general purpose
  // ==========================================================
  always_comb begin
    ser_out = '0;
    ser_oe  = '0;
    if (m_en) begin
      ser_out[PIN_CLK]  = sclk_r;
      ser_out[PIN_SIMO] = out_bit_r;
      ser_out[PIN_CS]   = cs_n_r;
      ser_oe[PIN_CLK]   = 1'b1;
      ser_oe[PIN_SIMO]  = 1'b1;
      ser_oe[PIN_CS]    = ctrl_r.cs_use;
    end else if (s_en) begin
      // Data out only while addressed, so slaves can share it
      ser_out[PIN_SOMI] = out_bit_r;
      ser_oe[PIN_SOMI]  = sel;
      // Enable low tells the master a word is ready
      ser_out[PIN_ENA]  = !armed_r;
      ser_oe[PIN_ENA]   = ctrl_r.ena_use;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pin_out_r <= '0;
      pin_oe_r  <= '0;
    end else begin
      for (int i = 0; i < N_PIN; i++) begin
        pin_out_r[i] <= func_r[i] ? ser_out[i] : dout_r[i];
        pin_oe_r[i]  <= func_r[i] ? ser_oe[i]  : dir_r[i];
      end
    end
  end

  assign rdata   = rdata_r;
  assign irq     = irq_r;
  assign pin_out = pin_out_r;
  assign pin_oe  = pin_oe_r;

endmodule

// ==== testbench/spi_port_properties.sv ====
module spi_port_props
  import spi_pkg::*;
(
  input wire logic              clk,
  input wire logic              rst_b,
  input wire bus_req_s          bus,
  input wire logic [DATA_W-1:0] rdata,
  input wire logic              irq,
  input wire logic [N_PIN-1:0]  pin_in,
  input wire logic [N_PIN-1:0]  pin_out,
  input wire logic [N_PIN-1:0]  pin_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================
  // Shadow state
  // ==========================================
  ctrl_s            ctrl_r;  // Control as written
  logic [N_PIN-1:0] pdir_r;  // Direction as written
  logic [N_PIN-1:0] pfunc_r; // Function as written
  logic [7:0]       gap_r;   // Cycles since clock pin moved
  logic [2:0]       ena_r;   // Cycles enable seen high
  logic             sclk_r;  // Clock pin a cycle ago

  // Copies of writes; the bodies are not visible here
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ctrl_r  <= CTRL_RST;
      pdir_r  <= '0;
      pfunc_r <= PFUNC_RST;
    end else if (bus.wr) begin
      case (bus.addr)
        OFS_CTRL:  ctrl_r  <= bus.wdata[10:0];
        OFS_PDIR:  pdir_r  <= bus.wdata[N_PIN-1:0];
        OFS_PFUNC: pfunc_r <= bus.wdata[N_PIN-1:0];
        default: ;
      endcase
    end
  end

  // Pacing counters, saturating so they never wrap
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      sclk_r <= 1'b0;
      gap_r  <= 8'hff;
      ena_r  <= 3'h0;
    end else begin
      sclk_r <= pin_out[PIN_CLK];
      gap_r  <= (pin_out[PIN_CLK] != sclk_r) ? 8'h01 :
                (gap_r == 8'hff) ? gap_r : gap_r + 8'h01;
      ena_r  <= !pin_in[PIN_ENA] ? 3'h0 :
                (ena_r == 3'h7) ? ena_r : ena_r + 3'h1;
    end
  end

  // ==========================================
  // Properties
  // ==========================================
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  property p_flags_clr;
    bus.rd && bus.addr == OFS_FLAGS |-> ##3 !irq;
  endproperty
  a_flags_clr: assert property (p_flags_clr)
    else $error("irq held after flag read");
  property p_buf_clr;
    bus.rd && bus.addr == OFS_RXBUF |-> ##3 !irq;
  endproperty
  a_buf_clr: assert property (p_buf_clr)
    else $error("irq held after buffer read");
  property p_mirror;
    bus.rd && bus.addr == OFS_RXMIR && irq
      |=> irq && rdata[DATA_W-1:WORD_W] == '0;
  endproperty
  a_mirror: assert property (p_mirror)
    else $error("mirror read had side effects");
  property p_vec_clr;
    (bus.rd && bus.addr == OFS_VEC0) ##1
      (rdata == 32'h1 && bus.rd && bus.addr == OFS_FLAGS)
      |=> !rdata[EV_RX];
  endproperty
  a_vec_clr: assert property (p_vec_clr)
    else $error("rx flag kept after vector read");
  property p_idle_pol;
    ctrl_r.master && pin_oe[PIN_CS] && pin_out[PIN_CS] &&
      $past(pin_out[PIN_CS]) |-> pin_out[PIN_CLK] == ctrl_r.pol;
  endproperty
  a_idle_pol: assert property (p_idle_pol)
    else $error("idle clock level wrong");
  property p_ena_wait;
    ctrl_r.master && ctrl_r.ena_use && ena_r == 3'h7
      |=> $stable(pin_out[PIN_CLK]);
  endproperty
  a_ena_wait: assert property (p_ena_wait)
    else $error("clock moved while slave not ready");
  property p_rate;
    ctrl_r.master && pin_oe[PIN_CLK] && pin_out[PIN_CLK] != sclk_r
      |-> gap_r >= HALF_MIN;
  endproperty
  a_rate: assert property (p_rate)
    else $error("serial clock too fast");
  property p_gpio_dir;
    pfunc_r == '0 && bus.wr && bus.addr == OFS_PDIR
      |=> ##[0:2] pin_oe == pdir_r;
  endproperty
  a_gpio_dir: assert property (p_gpio_dir)
    else $error("pin enables ignore direction");
  c_vec0: cover property (bus.rd && bus.addr == OFS_VEC0 ##1 rdata == 32'h1);
  c_vec1: cover property (bus.rd && bus.addr == OFS_VEC1 ##1 rdata == 32'h2);
  c_wait: cover property (ctrl_r.ena_use && ena_r == 3'h7);
endmodule

bind spi_port spi_port_props chk_u (.clk, .rst_b, .bus, .rdata, .irq,
  .pin_in, .pin_out, .pin_oe);

// ==== testbench/spi_slave_model.sv ====
module spi_slave_model
(
  input  wire logic        clk,
  input  wire logic        sclk,
  input  wire logic        simo,
  input  wire logic        cs_b,
  input  wire logic        ready,
  input  wire logic [15:0] tx_word,
  output logic             somi,
  output logic             ena_b,
  output logic [15:0]      rx_word
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] sh_r;          // Outgoing word, rotates back
  logic        junk_r = 1'b0; // Noise while deselected

  // Released line shows a changing pattern, not old data
  always @(posedge clk) junk_r <= ~junk_r;
  // Word loads on select
  always @(negedge cs_b) sh_r = tx_word;
  // Sample on leading edge, mode zero
  always @(posedge sclk) if (!cs_b) rx_word <= {rx_word[14:0], simo};
  // Next bit out on trailing edge
  always @(negedge sclk) if (!cs_b) sh_r <= {sh_r[14:0], sh_r[15]};
  assign somi  = cs_b ? junk_r : sh_r[15];
  assign ena_b = ~ready; // Low once ready
endmodule

// ==== testbench/spi_port_tb_top.sv ====
module spi_port_tb_top import spi_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic              clk = 1'b0;   // Peripheral clock
  logic              rst_b = 1'b0; // Sync reset
  bus_req_s          bus = '0;     // Register request
  logic [DATA_W-1:0] rdata, got;   // Read data, last read
  logic              irq, somi, ena_b;
  logic              ready = 1'b0; // Far side readiness
  logic mclk = 1'b0, mdo = 1'b0, mcs = 1'b1; // Far master pins
  logic [N_PIN-1:0]  pin_in, pin_out, pin_oe, far;
  logic [15:0]       tx_word = 16'h3c5a;
  logic [15:0]       rx_word;
  int bad_count, comparisons, sclk_edges, cs_rises;

  always #25 clk = ~clk;
  always @(posedge pin_out[PIN_CLK]) sclk_edges++;
  always @(posedge pin_out[PIN_CS]) cs_rises++;
  // Driver wins; undriven lines read as the far side
  assign far    = {ena_b, mcs, somi, mdo, mclk};
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & far);

  spi_port dut_u (.clk, .rst_b, .bus, .rdata, .irq, .pin_in, .pin_out,
    .pin_oe);
  spi_slave_model slave_u (.clk, .sclk(pin_out[PIN_CLK]), .ready,
    .simo(pin_out[PIN_SIMO]), .cs_b(pin_out[PIN_CS]), .tx_word,
    .somi, .ena_b, .rx_word);

  // ==========================================
  // Bus and check helpers
  // ==========================================
  // One access; strobe held for one edge only
  task automatic acc(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    bus <= '{addr: a, wdata: d, wr: w, rd: !w};
    @(posedge clk);
    bus <= '0;
    #1 got = rdata;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] exp);
    acc(1'b0, a, 32'h0);
    check(got, exp);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Bounded wait; a word takes well under this
  task automatic wait_irq(input logic lvl);
    for (int i = 0; i < 1000 && irq !== lvl; i++) @(posedge clk);
    #1;
    check(32'(irq), 32'(lvl));
  endtask
  task automatic stop_test;
    if (bad_count == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // ==========================================
  // Scenarios
  // ==========================================
  task automatic t_reset;
    rc(OFS_CTRL, 32'h780);
    rc(OFS_DIV, 32'h4);
    rc(8'h30, 32'h0);
    check(32'(pin_oe), 32'h0);
  endtask
  task automatic t_gpio;
    acc(1'b1, OFS_PDOUT, 32'h1f);
    acc(1'b1, OFS_PDIR, 32'h3);
    idle(4);
    check(32'(pin_oe), 32'h3);
    acc(1'b0, OFS_PDIN, 32'h0);
    check(got & 32'h1b, 32'h1b);
    acc(1'b1, OFS_PDIR, 32'h0);
    acc(1'b1, OFS_PDOUT, 32'h0);
  endtask
  // Master word held off by a slow slave
  task automatic t_master;
    acc(1'b1, OFS_MASK, 32'h1);
    acc(1'b1, OFS_CTRL, 32'h7b3);
    acc(1'b1, OFS_PFUNC, 32'h1f);
    sclk_edges = 0;
    acc(1'b1, OFS_TXDATA, 32'ha5c3);
    idle(60);
    check(32'(sclk_edges), 32'h0);
    ready <= 1'b1;
    wait_irq(1'b1);
    check(32'(sclk_edges), 32'h10);
    check(32'(rx_word), 32'ha5c3);
    rc(OFS_RXMIR, 32'h3c5a);
    check(32'(irq), 32'h1);
    rc(OFS_VEC0, 32'h1);
    rc(OFS_FLAGS, 32'h4);
    rc(OFS_FLAGS, 32'h0);
  endtask
  // Two held-select words into an unread buffer
  task automatic t_overrun;
    acc(1'b1, OFS_LEVEL, 32'h2);
    acc(1'b1, OFS_MASK, 32'h2);
    acc(1'b1, OFS_CTRL, 32'h7f3);
    cs_rises = 0;
    acc(1'b1, OFS_TXDATA, 32'h1234);
    idle(3);
    acc(1'b1, OFS_TXDATA, 32'h5678);
    wait_irq(1'b1);
    rc(OFS_VEC1, 32'h2);
    wait_irq(1'b0);
    wait_irq(1'b1);
    rc(OFS_VEC1, 32'h2);
    idle(8);
    check(32'(cs_rises), 32'h1);
    check(32'(rx_word), 32'h5678);
    rc(OFS_RXBUF, 32'h13c5a);
    rc(OFS_FLAGS, 32'h0);
    acc(1'b0, OFS_RXBUF, 32'h0);
    check(got & 32'h10000, 32'h0);
  endtask
  // Slave: two words under one held select
  task automatic t_slave;
    logic [31:0] sw = 32'hc3a55a3c;
    acc(1'b1, OFS_CTRL, 32'h7d1);
    mcs <= 1'b0;
    for (int i = 31; i >= 0; i--) begin
      mdo  <= sw[i];
      idle(4);
      mclk <= 1'b1;
      idle(4);
      mclk <= 1'b0;
    end
    idle(4);
    mcs <= 1'b1;
    rc(OFS_RXBUF, 32'h15a3c);
  endtask

  // Watchdog, well past the expected run
  initial begin
    #200000;
    bad_count++;
    stop_test();
  end
  initial begin
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    idle(1);
    t_reset();
    t_gpio();
    t_master();
    t_overrun();
    t_slave();
    stop_test();
  end
endmodule
